// ### hw/mirq_pkg.sv
// Constants and types shared by the motion interrupt enable and pin control block.
package mirq_pkg;

    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 50;
    localparam int HOLD_BASE_NS     = 312500;
    localparam int HOLD_BASE_CYCLES = (HOLD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CNT_W       = 26;

    // ************************************************************
    // Register offsets and masks.
    // ************************************************************
    localparam logic [7:0] OFS_EN_MOTION_TAP   = 8'h50;
    localparam logic [7:0] OFS_EN_FIFO_HIGHG   = 8'h51;
    localparam logic [7:0] OFS_EN_NOMOTION_STEP = 8'h52;
    localparam logic [7:0] OFS_PIN_CONFIG      = 8'h53;
    localparam logic [7:0] OFS_LATCH_CTRL      = 8'h54;
    localparam logic [7:0] MASK_EN_MOTION_TAP  = 8'hF7;
    localparam logic [7:0] MASK_EN_FIFO_HIGHG  = 8'h7F;
    localparam logic [7:0] MASK_EN_NOMOTION    = 8'h0F;
    localparam logic [7:0] MASK_PIN_CONFIG     = 8'hFF;
    localparam logic [7:0] MASK_LATCH_CTRL     = 8'h3F;
    localparam logic [7:0] REG_RESET           = 8'h00;
    localparam logic [7:0] READ_UNMAPPED       = 8'h00;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int PB_DRIVE_EN = 7;
    localparam int PB_OPENDRAIN = 6;
    localparam int PB_POLARITY = 5;
    localparam int PB_PULSE    = 4;
    localparam int PA_DRIVE_EN = 3;
    localparam int PA_OPENDRAIN = 2;
    localparam int PA_POLARITY = 1;
    localparam int PA_PULSE    = 0;
    localparam int LT_CLEAR    = 7;
    localparam int LT_IN_EN_B  = 5;
    localparam int LT_IN_EN_A  = 4;
    localparam int EVT_FIFO_WMARK = 14;
    localparam int EVT_W       = 24;

    // ************************************************************
    // Latch modes.
    // ************************************************************
    localparam logic [3:0] MODE_NONLATCHED = 4'h0;
    localparam logic [3:0] MODE_LATCHED    = 4'hF;

    typedef enum logic [2:0] {
        PST_IDLE  = 3'b001,
        PST_HOLD  = 3'b010,
        PST_LATCH = 3'b100
    } mirq_pin_state_t;

    // Cycles a temporary mode holds the line, doubling per mode step.
    function automatic logic [HOLD_CNT_W-1:0] hold_cycles(input logic [HOLD_CNT_W-1:0] base,
                                                         input logic [3:0] mode);
        logic [3:0] sh;
        sh = mode - 4'h1;
        hold_cycles = base << sh;
    endfunction

endpackage

// ### hw/mirq_sync.sv
// Two-flop synchroniser for the two interrupt pin input levels.
`timescale 1ns/10ps
module mirq_sync (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Asynchronous levels in, synchronous levels out.
    input  wire logic [1:0] d,
    output logic      [1:0] q
);

    logic [1:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 2'h0;
            q        <= 2'h0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule // mirq_sync

// ### hw/mirq_pin_drv.sv
// Latch, pulse, polarity and drive stage of one interrupt pin.
`timescale 1ns/10ps
module mirq_pin_drv #(
    parameter logic [mirq_pkg::HOLD_CNT_W-1:0] BASE = 26'(mirq_pkg::HOLD_BASE_CYCLES)
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Request and configuration.
    input  wire logic       req,
    input  wire logic [3:0] mode,
    input  wire logic       latch_clr,
    input  wire logic       drive_en,
    input  wire logic       opendrain,
    input  wire logic       polarity,
    input  wire logic       pulse_sel,
    // Pin drive.
    output logic            pin_o,
    output logic            pin_oe
);

    mirq_pkg::mirq_pin_state_t st_reg;
    logic [mirq_pkg::HOLD_CNT_W-1:0] cnt_reg;
    logic active_reg;
    logic active_d_reg;
    logic asserted;
    logic level;

    // ************************************************************
    // Line holding.
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg  <= mirq_pkg::PST_IDLE;
            cnt_reg <= '0;
        end else begin
            unique case (st_reg)
                mirq_pkg::PST_IDLE: begin
                    if (req && mode == mirq_pkg::MODE_LATCHED) begin
                        st_reg <= mirq_pkg::PST_LATCH; // [R16]
                    end else if (req && mode != mirq_pkg::MODE_NONLATCHED) begin
                        st_reg  <= mirq_pkg::PST_HOLD; // [R16]
                        cnt_reg <= mirq_pkg::hold_cycles(BASE, mode) - 26'h1;
                    end
                end
                mirq_pkg::PST_HOLD: begin
                    if (req) begin
                        cnt_reg <= mirq_pkg::hold_cycles(BASE, mode) - 26'h1;
                    end else if (cnt_reg == '0) begin
                        st_reg <= mirq_pkg::PST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 26'h1;
                    end
                end
                mirq_pkg::PST_LATCH: begin
                    // A new request in the clearing cycle keeps the line latched.
                    if (latch_clr && !req) begin
                        st_reg <= mirq_pkg::PST_IDLE;
                    end
                end
                default: st_reg <= mirq_pkg::PST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_reg   <= 1'b0;
            active_d_reg <= 1'b0;
        end else begin
            active_reg   <= req || st_reg != mirq_pkg::PST_IDLE;
            active_d_reg <= active_reg;
        end
    end

    // ************************************************************
    // Electrical stage.
    // ************************************************************
    assign asserted = pulse_sel ? (active_reg && !active_d_reg) : active_reg; // [R10] [R14]
    assign level    = polarity ? asserted : !asserted; // [R8] [R13]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b0;
        end else if (!drive_en) begin
            pin_o  <= 1'b0; // [R6] [R11] [R15]
            pin_oe <= 1'b0;
        end else if (opendrain) begin
            pin_o  <= 1'b0; // [R7] [R12]
            pin_oe <= !level;
        end else begin
            pin_o  <= level;
            pin_oe <= 1'b1;
        end
    end

    a_drive_off_float: assert property (@(posedge clk) disable iff (rst)
        !drive_en |=> !pin_oe) else $error("pin driven while output disabled"); // [R6]
    a_opendrain_never_high: assert property (@(posedge clk) disable iff (rst)
        drive_en && opendrain |=> !pin_o && pin_oe == !($past(polarity) ~^ $past(asserted)))
        else $error("open-drain pin drove high or wrong"); // [R7]
    a_pushpull_polarity: assert property (@(posedge clk) disable iff (rst)
        drive_en && !opendrain |=> pin_oe && pin_o == ($past(polarity) ~^ $past(asserted)))
        else $error("push-pull level wrong"); // [R8]
    a_edge_single_cycle: assert property (@(posedge clk) disable iff (rst)
        pulse_sel && asserted ##1 pulse_sel |-> !asserted)
        else $error("edge signal longer than one cycle"); // [R10]
    a_latch_holds: assert property (@(posedge clk) disable iff (rst)
        st_reg == mirq_pkg::PST_LATCH && !latch_clr |=> st_reg == mirq_pkg::PST_LATCH)
        else $error("latched line dropped without clear"); // [R16]
    c_latched: cover property (@(posedge clk) disable iff (rst)
        st_reg == mirq_pkg::PST_LATCH ##1 st_reg == mirq_pkg::PST_IDLE);
    c_hold_expire: cover property (@(posedge clk) disable iff (rst)
        st_reg == mirq_pkg::PST_HOLD ##1 st_reg == mirq_pkg::PST_IDLE);

endmodule // mirq_pin_drv

// ### hw/mirq_top.sv
// Interrupt engine enables and interrupt pin electrical configuration.
//
// What this block does
// [R1] Enable bit zero blocks engine, one allows it.
// [R2] First enable byte: flat, orient, taps, anymotion.
// [R3] Second byte: watermark, full, ready, low-g, high-g.
// [R4] Third byte: step detector, no-motion z y x.
// [R5] All four bytes read/write, reset to zero.
// [R6] Bit 7 enables pin B output drive.
// [R7] Bit 6 picks pin B open-drain, when enabled.
// [R8] Bit 5 pin B polarity: output or wake.
// [R9] Frame marking ignores pin polarity, both pins.
// [R10] Bit 4 makes pin B edge signalled.
// [R11] Bit 3 enables pin A output drive.
// [R12] Bit 2 picks pin A open-drain, when enabled.
// [R13] Bit 1 pin A polarity: output or wake.
// [R14] Bit 0 makes pin A edge signalled.
// [R15] Edge selection only counts while output enabled.
// [R16] Four-bit mode: non-latched, temporary or latched.
// [R17] Watermark fires when fill exceeds programmed level.
// [R18] Disabled engine never asserts any pin.
`timescale 1ns/10ps
module mirq_top #(
    parameter logic [mirq_pkg::HOLD_CNT_W-1:0] HOLD_BASE = 26'(mirq_pkg::HOLD_BASE_CYCLES)
) (
    // Clock and reset.
    input  wire logic        MCLK,
    input  wire logic        RST,
    // Register port.
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WE,
    input  wire logic        REG_RE,
    output logic      [7:0]  REG_RDATA,
    // Engine events and enables.
    input  wire logic [23:0] ENGINE_EVT,
    output logic      [23:0] ENGINE_ENABLE,
    output logic      [23:0] EVENT_GATED,
    // FIFO level.
    input  wire logic [7:0]  FIFO_FILL_WORDS,
    input  wire logic [7:0]  FIFO_WATERMARK,
    // Event to pin mapping.
    input  wire logic [23:0] MAP_PIN_A,
    input  wire logic [23:0] MAP_PIN_B,
    // Frame marking enables.
    input  wire logic        FRAME_MARK_PIN_A_ENABLE,
    input  wire logic        FRAME_MARK_PIN_B_ENABLE,
    // Pin A.
    input  wire logic        IRQ_PIN_A_I,
    output logic             IRQ_PIN_A_O,
    output logic             IRQ_PIN_A_OE,
    // Pin B.
    input  wire logic        IRQ_PIN_B_I,
    output logic             IRQ_PIN_B_O,
    output logic             IRQ_PIN_B_OE,
    // Pin input functions.
    output logic      [1:0]  POWER_UNIT_WAKE_INPUT,
    output logic             FRAME_MARK_A,
    output logic             FRAME_MARK_B
);

    // ************************************************************
    // Registers.
    // ************************************************************
    logic [7:0]  irq_enable_motion_tap_reg;
    logic [7:0]  irq_enable_fifo_highg_reg;
    logic [7:0]  irq_enable_nomotion_step_reg;
    logic [7:0]  irq_pin_electrical_config_reg;
    logic [7:0]  latch_ctrl_reg;
    logic        latch_clr_reg;
    logic [7:0]  rdata_next;
    logic [23:0] enable_all;

    // Reserved positions are masked on write so they always read zero.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            irq_enable_motion_tap_reg     <= mirq_pkg::REG_RESET; // [R5]
            irq_enable_fifo_highg_reg     <= mirq_pkg::REG_RESET;
            irq_enable_nomotion_step_reg  <= mirq_pkg::REG_RESET;
            irq_pin_electrical_config_reg <= mirq_pkg::REG_RESET;
            latch_ctrl_reg                <= mirq_pkg::REG_RESET;
        end else if (REG_WE) begin
            unique case (REG_ADDR)
                mirq_pkg::OFS_EN_MOTION_TAP: begin
                    irq_enable_motion_tap_reg <= REG_WDATA & mirq_pkg::MASK_EN_MOTION_TAP; // [R2]
                end
                mirq_pkg::OFS_EN_FIFO_HIGHG: begin
                    irq_enable_fifo_highg_reg <= REG_WDATA & mirq_pkg::MASK_EN_FIFO_HIGHG; // [R3]
                end
                mirq_pkg::OFS_EN_NOMOTION_STEP: begin
                    irq_enable_nomotion_step_reg <= REG_WDATA & mirq_pkg::MASK_EN_NOMOTION; // [R4]
                end
                mirq_pkg::OFS_PIN_CONFIG: begin
                    irq_pin_electrical_config_reg <= REG_WDATA & mirq_pkg::MASK_PIN_CONFIG;
                end
                mirq_pkg::OFS_LATCH_CTRL: begin
                    latch_ctrl_reg <= REG_WDATA & mirq_pkg::MASK_LATCH_CTRL;
                end
                default: begin
                end
            endcase
        end
    end

    // Writing the clear bit gives a single-cycle release of latched lines.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            latch_clr_reg <= 1'b0;
        end else begin
            latch_clr_reg <= REG_WE && REG_ADDR == mirq_pkg::OFS_LATCH_CTRL
                             && REG_WDATA[mirq_pkg::LT_CLEAR];
        end
    end

    always_comb begin
        unique case (REG_ADDR)
            mirq_pkg::OFS_EN_MOTION_TAP:    rdata_next = irq_enable_motion_tap_reg;
            mirq_pkg::OFS_EN_FIFO_HIGHG:    rdata_next = irq_enable_fifo_highg_reg;
            mirq_pkg::OFS_EN_NOMOTION_STEP: rdata_next = irq_enable_nomotion_step_reg;
            mirq_pkg::OFS_PIN_CONFIG:       rdata_next = irq_pin_electrical_config_reg;
            mirq_pkg::OFS_LATCH_CTRL:       rdata_next = latch_ctrl_reg;
            default:                        rdata_next = mirq_pkg::READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RE) begin
            REG_RDATA <= rdata_next;
        end
    end

    // ************************************************************
    // Engine gating.
    // ************************************************************
    logic        wmark_over_reg;
    logic        wmark_over;
    logic        wmark_rise;
    logic [23:0] evt_src;

    assign enable_all = {irq_enable_nomotion_step_reg,
                         irq_enable_fifo_highg_reg,
                         irq_enable_motion_tap_reg};

    // Only the crossing fires, so a FIFO parked above the level raises one event.
    assign wmark_over = FIFO_FILL_WORDS > FIFO_WATERMARK; // [R17]
    assign wmark_rise = wmark_over && !wmark_over_reg;

    always_comb begin
        evt_src = ENGINE_EVT;
        evt_src[mirq_pkg::EVT_FIFO_WMARK] = ENGINE_EVT[mirq_pkg::EVT_FIFO_WMARK] || wmark_rise;
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            wmark_over_reg <= 1'b0;
        end else begin
            wmark_over_reg <= wmark_over;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ENGINE_ENABLE <= 24'h000000;
            EVENT_GATED   <= 24'h000000;
        end else begin
            ENGINE_ENABLE <= enable_all; // [R1]
            EVENT_GATED   <= evt_src & enable_all; // [R1] [R18]
        end
    end

    // ************************************************************
    // Pin drive.
    // ************************************************************
    logic req_a;
    logic req_b;

    // Only gated events reach the pins, whatever the mapping asks for.
    assign req_a = |(EVENT_GATED & MAP_PIN_A); // [R18]
    assign req_b = |(EVENT_GATED & MAP_PIN_B); // [R18]

    mirq_pin_drv #(
        .BASE (HOLD_BASE)
    ) u_pin_a (
        .clk       (MCLK),
        .rst       (RST),
        .req       (req_a),
        .mode      (latch_ctrl_reg[3:0]),
        .latch_clr (latch_clr_reg),
        .drive_en  (irq_pin_electrical_config_reg[mirq_pkg::PA_DRIVE_EN]),
        .opendrain (irq_pin_electrical_config_reg[mirq_pkg::PA_OPENDRAIN]),
        .polarity  (irq_pin_electrical_config_reg[mirq_pkg::PA_POLARITY]),
        .pulse_sel (irq_pin_electrical_config_reg[mirq_pkg::PA_PULSE]),
        .pin_o     (IRQ_PIN_A_O),
        .pin_oe    (IRQ_PIN_A_OE)
    );

    mirq_pin_drv #(
        .BASE (HOLD_BASE)
    ) u_pin_b (
        .clk       (MCLK),
        .rst       (RST),
        .req       (req_b),
        .mode      (latch_ctrl_reg[3:0]),
        .latch_clr (latch_clr_reg),
        .drive_en  (irq_pin_electrical_config_reg[mirq_pkg::PB_DRIVE_EN]),
        .opendrain (irq_pin_electrical_config_reg[mirq_pkg::PB_OPENDRAIN]),
        .polarity  (irq_pin_electrical_config_reg[mirq_pkg::PB_POLARITY]),
        .pulse_sel (irq_pin_electrical_config_reg[mirq_pkg::PB_PULSE]),
        .pin_o     (IRQ_PIN_B_O),
        .pin_oe    (IRQ_PIN_B_OE)
    );

    // ************************************************************
    // Pin input functions.
    // ************************************************************
    logic [1:0] pin_sync;
    logic       drive_a;
    logic       drive_b;
    logic       pol_a;
    logic       pol_b;
    logic       in_en_a;
    logic       in_en_b;

    mirq_sync u_sync (
        .clk (MCLK),
        .rst (RST),
        .d   ({IRQ_PIN_B_I, IRQ_PIN_A_I}),
        .q   (pin_sync)
    );

    assign drive_a = irq_pin_electrical_config_reg[mirq_pkg::PA_DRIVE_EN];
    assign drive_b = irq_pin_electrical_config_reg[mirq_pkg::PB_DRIVE_EN];
    assign pol_a   = irq_pin_electrical_config_reg[mirq_pkg::PA_POLARITY];
    assign pol_b   = irq_pin_electrical_config_reg[mirq_pkg::PB_POLARITY];
    assign in_en_a = latch_ctrl_reg[mirq_pkg::LT_IN_EN_A];
    assign in_en_b = latch_ctrl_reg[mirq_pkg::LT_IN_EN_B];

    // With the output off, polarity qualifies the wake trigger instead.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            POWER_UNIT_WAKE_INPUT <= 2'h0;
        end else begin
            POWER_UNIT_WAKE_INPUT[0] <= !drive_a && in_en_a && (pol_a ~^ pin_sync[0]); // [R13]
            POWER_UNIT_WAKE_INPUT[1] <= !drive_b && in_en_b && (pol_b ~^ pin_sync[1]); // [R8]
        end
    end

    // Frame marking reads the raw level as active high on purpose.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            FRAME_MARK_A <= 1'b0;
            FRAME_MARK_B <= 1'b0;
        end else begin
            FRAME_MARK_A <= FRAME_MARK_PIN_A_ENABLE && in_en_a && pin_sync[0]; // [R9]
            FRAME_MARK_B <= FRAME_MARK_PIN_B_ENABLE && in_en_b && pin_sync[1]; // [R9]
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    a_reset_all_zero: assert property (@(posedge MCLK)
        $past(RST) |-> ENGINE_ENABLE == 24'h000000 && irq_pin_electrical_config_reg == 8'h00
        && !IRQ_PIN_A_OE && !IRQ_PIN_B_OE) else $error("state not zero after reset"); // [R5]
    a_gate_blocks_event: assert property (@(posedge MCLK) disable iff (RST)
        ##1 (EVENT_GATED & ~$past(enable_all)) == 24'h000000)
        else $error("disabled engine raised event"); // [R1]
    a_gate_passes_event: assert property (@(posedge MCLK) disable iff (RST)
        (ENGINE_EVT & enable_all) != 24'h000000 |=> EVENT_GATED != 24'h000000)
        else $error("enabled engine event lost"); // [R1]
    a_reserved_read_zero: assert property (@(posedge MCLK) disable iff (RST)
        REG_RE && REG_ADDR == mirq_pkg::OFS_EN_MOTION_TAP |=> !REG_RDATA[3])
        else $error("reserved bit reads one"); // [R2]
    a_reserved_hi_zero: assert property (@(posedge MCLK) disable iff (RST)
        REG_RE && REG_ADDR == mirq_pkg::OFS_EN_NOMOTION_STEP |=> REG_RDATA[7:4] == 4'h0)
        else $error("reserved nibble reads nonzero"); // [R4]
    a_write_read_back: assert property (@(posedge MCLK) disable iff (RST)
        REG_WE && REG_ADDR == mirq_pkg::OFS_EN_FIFO_HIGHG ##1 REG_RE && !REG_WE
        && REG_ADDR == mirq_pkg::OFS_EN_FIFO_HIGHG
        |=> REG_RDATA == ($past(REG_WDATA, 2) & mirq_pkg::MASK_EN_FIFO_HIGHG))
        else $error("enable byte read-back wrong"); // [R3]
    a_wmark_fires: assert property (@(posedge MCLK) disable iff (RST)
        wmark_over && !wmark_over_reg && enable_all[mirq_pkg::EVT_FIFO_WMARK]
        |=> EVENT_GATED[mirq_pkg::EVT_FIFO_WMARK]) else $error("watermark event missing"); // [R17]
    a_disabled_no_pin: assert property (@(posedge MCLK) disable iff (RST)
        enable_all == 24'h000000 && $past(enable_all) == 24'h000000
        |-> !req_a && !req_b) else $error("pin request with all engines off"); // [R18]
    a_wake_off_driving: assert property (@(posedge MCLK) disable iff (RST)
        drive_a |=> !POWER_UNIT_WAKE_INPUT[0]) else $error("wake seen while pin A drives"); // [R13]
    a_mark_ignores_pol: assert property (@(posedge MCLK) disable iff (RST)
        FRAME_MARK_PIN_B_ENABLE && in_en_b |=> FRAME_MARK_B == $past(pin_sync[1]))
        else $error("frame mark follows polarity"); // [R9]
    c_pin_a_asserts: cover property (@(posedge MCLK) disable iff (RST)
        req_a && drive_a ##2 IRQ_PIN_A_OE);
    c_wake_seen: cover property (@(posedge MCLK) disable iff (RST)
        POWER_UNIT_WAKE_INPUT[1]);
    c_wmark_event: cover property (@(posedge MCLK) disable iff (RST)
        EVENT_GATED[mirq_pkg::EVT_FIFO_WMARK]);

endmodule // mirq_top

// ### tb/mirq_host.sv
// Host model: resolves both interrupt lines and may drive them while released.
`timescale 1ns/10ps
module mirq_host (
    // Device pin drive.
    input  wire logic       pin_a_o,
    input  wire logic       pin_a_oe,
    input  wire logic       pin_b_o,
    input  wire logic       pin_b_oe,
    // Host drive of the lines, bit 0 pin A.
    input  wire logic [1:0] host_drive,
    input  wire logic [1:0] host_level,
    // Resolved line levels.
    output logic            pin_a_level,
    output logic            pin_b_level
);
    // Released lines float to the pull-up, as open-drain drive needs.
    assign pin_a_level = pin_a_oe ? pin_a_o : (host_drive[0] ? host_level[0] : 1'b1);
    assign pin_b_level = pin_b_oe ? pin_b_o : (host_drive[1] ? host_level[1] : 1'b1);
endmodule // mirq_host

// ### tb/testbench.sv
// Self-checking bench for the motion interrupt enable and pin control block.
`timescale 1ns/10ps
module testbench;
    logic        mclk, rst, we, re, a_i, a_o, a_oe, b_i, b_o, b_oe, fm_a, fm_b, sw;
    logic [7:0]  addr, wdata, rdata, fill, wmark, d;
    logic [23:0] evt, en, gated, r;
    logic [1:0]  wake, hdrv, hlvl;
    int          bad_count, compares, cycles;
    localparam logic [7:0] MSK [4] = '{mirq_pkg::MASK_EN_MOTION_TAP, mirq_pkg::MASK_EN_FIFO_HIGHG,
                                       mirq_pkg::MASK_EN_NOMOTION, mirq_pkg::MASK_PIN_CONFIG};
    mirq_top #(.HOLD_BASE(26'h4)) mirq_top_inst (.MCLK(mclk), .RST(rst), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .ENGINE_EVT(evt),
        .ENGINE_ENABLE(en), .EVENT_GATED(gated), .FIFO_FILL_WORDS(fill), .FIFO_WATERMARK(wmark),
        .MAP_PIN_A(24'hFFFFFF), .MAP_PIN_B(24'hFFFFFF), .FRAME_MARK_PIN_A_ENABLE(1'b1),
        .FRAME_MARK_PIN_B_ENABLE(1'b1), .IRQ_PIN_A_I(a_i), .IRQ_PIN_A_O(a_o), .IRQ_PIN_A_OE(a_oe),
        .IRQ_PIN_B_I(b_i), .IRQ_PIN_B_O(b_o), .IRQ_PIN_B_OE(b_oe), .POWER_UNIT_WAKE_INPUT(wake),
        .FRAME_MARK_A(fm_a), .FRAME_MARK_B(fm_b));
    mirq_host mirq_host_inst (.pin_a_o(a_o), .pin_a_oe(a_oe), .pin_b_o(b_o), .pin_b_oe(b_oe),
        .host_drive(hdrv), .host_level(hlvl), .pin_a_level(a_i), .pin_b_level(b_i));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge mclk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        re <= 1'b1;
        @(posedge mclk);
        re <= 1'b0;
        @(negedge mclk);
        chk(24'(rdata), 24'(exp));
    endtask
    // Pin nibble {drive, opendrain, polarity, pulse}; result {oe, o}.
    function automatic logic [1:0] exp_pin(input logic [3:0] c, input logic act);
        logic lvl;
        lvl = act ? c[1] : ~c[1];
        if (!c[3]) return 2'b00;
        if (c[2]) return {~lvl, 1'b0};
        return {1'b1, lvl};
    endfunction
    task automatic print_verdict;
        if (bad_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hA5E3));
        {rst, we, re, addr, wdata, evt, fill, wmark, hdrv, hlvl} = '0;
        rst = 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) rd(8'h50 + 8'(i), 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            wr(8'h50 + 8'(i), d);
            rd(8'h50 + 8'(i), d & MSK[i]);
        end
        wr(8'h60, 8'hFF);
        rd(8'h60, 8'h00);
        for (int k = 0; k < 6; k++) begin
            r = 24'($urandom);
            for (int i = 0; i < 3; i++) wr(8'h50 + 8'(i), r[8*i +: 8]);
            r = r & {MSK[2], MSK[1], MSK[0]};
            @(posedge mclk);
            evt <= 24'($urandom) | 24'h000001;
            @(posedge mclk);
            chk(en, r);
            @(negedge mclk);
            chk(gated, evt & r);
            @(posedge mclk);
            evt <= 24'h0;
        end
        wr(8'h50, 8'h01);
        wr(8'h51, 8'h00);
        wr(8'h52, 8'h00);
        for (int n = 0; n < 16; n++) begin
            wr(8'h53, {2{4'(n)}});
            @(posedge mclk);
            evt <= 24'h1;
            repeat (2) @(posedge mclk);
            evt <= 24'h0;
            @(posedge mclk);
            @(negedge mclk);
            chk(24'({b_oe, b_o, a_oe, a_o}), 24'({2{exp_pin(4'(n), 1'b1)}}));
            @(negedge mclk);
            chk(24'({b_oe, b_o, a_oe, a_o}), 24'({2{exp_pin(4'(n), ~n[0])}}));
            repeat (2) @(negedge mclk);
            chk(24'({b_oe, b_o, a_oe, a_o}), 24'({2{exp_pin(4'(n), 1'b0)}}));
        end
        wr(8'h54, 8'h30);
        for (int k = 0; k < 8; k++) begin
            sw = 1'($urandom);
            wr(8'h53, sw ? 8'h22 : 8'h00);
            hdrv <= 2'b11;
            hlvl <= 2'($urandom);
            repeat (5) @(posedge mclk);
            @(negedge mclk);
            chk(24'(wake), 24'({~(hlvl ^ {2{sw}})}));
            chk(24'({fm_b, fm_a}), 24'(hlvl));
        end
        hdrv <= 2'b00;
        wr(8'h51, 8'h40);
        @(posedge mclk);
        wmark <= 8'h05;
        fill <= 8'h05;
        sw = 1'b0;
        repeat (4) @(negedge mclk) sw = sw | gated[14];
        chk(24'(sw), 24'h0);
        @(posedge mclk);
        fill <= 8'h06;
        repeat (4) @(negedge mclk) sw = sw | gated[14];
        chk(24'(sw), 24'h1);
        // Pin A push-pull active high: one temporary hold of four cycles, then latched.
        wr(8'h53, 8'h0A);
        for (int m = 0; m < 2; m++) begin
            wr(8'h54, (m != 0) ? 8'h0F : 8'h01);
            @(posedge mclk);
            evt <= 24'h1;
            @(posedge mclk);
            evt <= 24'h0;
            repeat (6) @(posedge mclk);
            @(negedge mclk);
            chk(24'({a_oe, a_o}), 24'h3);
            @(negedge mclk);
            chk(24'({a_oe, a_o}), (m != 0) ? 24'h3 : 24'h2);
        end
        wr(8'h54, 8'h80);
        repeat (4) @(negedge mclk);
        chk(24'({a_oe, a_o}), 24'h2);
        print_verdict();
    end
endmodule // testbench
